// File: dom_mode_sel.v
/*
 * Drive operation-mode selector: resolves external, panel, network or
 * combined mode from settings held in APB registers and from terminal pins.
 * Assumes a 40 MHz MCLK, asynchronous pins, and an APB master.
 */
`include "dom_map.vh"

module dom_mode_sel (
    input wire MCLK, // 40 MHz system clock
    input wire RST, // Async reset, high
    input wire PSEL, // APB select
    input wire PENABLE, // APB enable
    input wire PWRITE, // APB direction
    input wire [7:0] PADDR, // APB byte address
    input wire [31:0] PWDATA, // APB write data
    output reg [31:0] PRDATA, // APB read data
    output reg PREADY, // APB ready
    output reg PSLVERR, // APB error
    input wire [4:0] TERM_IN, // Function-selectable terminals
    input wire OUTPUT_STOP_IN, // Output-stop pin
    input wire FORWARD_START_IN, // Forward start pin
    input wire REVERSE_START_IN, // Reverse start pin
    input wire MOTOR_RUN_IN, // Motor running status
    output reg [3:0] MODE, // One-hot resolved mode
    output reg OUTPUT_STOP // Motor output held stopped
);

    // Settings and state
    reg [2:0] mode_selection_setting_r;
    reg [3:0] startup_mode_setting_r;
    reg [1:0] stop_input_logic_setting_r;
    reg [34:0] tfs_r;
    reg [3:0] mode_r;
    reg [3:0] mode_nxt;
    reg [1:0] cmd_r;
    reg cmd_pend_r;
    wire [8:0] pins_s;
    wire [4:0] term_s;
    wire output_stop_in;
    wire forward_start_in;
    wire reverse_start_in;
    wire motor_run;

    // Pin synchronisers
    dom_sync #(.W(9)) u_sync (
        .clk(MCLK),
        .rst(RST),
        .d({MOTOR_RUN_IN, REVERSE_START_IN, FORWARD_START_IN, OUTPUT_STOP_IN, TERM_IN}),
        .q(pins_s)
    );
    assign term_s = pins_s[4:0];
    assign output_stop_in = pins_s[5];
    assign forward_start_in = pins_s[6];
    assign reverse_start_in = pins_s[7];
    assign motor_run = pins_s[8];

    // Looks up a function code over the terminal selects: {assigned, level}
    function [1:0] term_find;
        input [6:0] code;
        integer i;
        begin
            term_find = 2'b00;
            for (i = 0; i < 5; i = i + 1) begin
                if (tfs_r[i*7 +: 7] == code) begin
                    term_find = {1'b1, term_find[0] | term_s[i]};
                end
            end
        end
    endfunction

    // Terminal function decode
    wire [1:0] fn_ilk = term_find(`DOM_FN_INTERLOCK);
    wire [1:0] fn_pe = term_find(`DOM_FN_PANEL_EXT);
    wire [1:0] fn_pn = term_find(`DOM_FN_PANEL_NET);
    wire [1:0] fn_en = term_find(`DOM_FN_EXT_NET);

    // Setting decode
    wire [2:0] mss = mode_selection_setting_r;
    wire [3:0] su = startup_mode_setting_r;
    wire mss_ilock = (mss == `DOM_MSS_ILOCK);
    wire mss_sw = (mss == `DOM_MSS_SWOVER);
    wire mss_fixed = (mss == `DOM_MSS_PANEL) || (mss == `DOM_MSS_COMB3) ||
        (mss == `DOM_MSS_COMB4);

    // Interlock source: dedicated terminal, else the stop pin with its logic
    wire stop_level = output_stop_in ^ (stop_input_logic_setting_r == `DOM_SL_INVERT);
    wire ilk_on = fn_ilk[1] ? fn_ilk[0] : stop_level;
    wire ilk_off = mss_ilock && !ilk_on;
    wire start_on = forward_start_in || reverse_start_in;
    wire stopped = !motor_run && !start_on;
    wire run_ok = stopped || mss_sw;

    // Input qualification
    wire en_ok = fn_en[1] && ((mss == `DOM_MSS_ANY) || (mss == `DOM_MSS_EXT) || mss_sw ||
        mss_ilock) && ((su == `DOM_SU_AS_MSS) || (su == `DOM_SU_NET));
    wire pn_ok = fn_pn[1] && ((mss == `DOM_MSS_ANY) || mss_sw || mss_ilock) &&
        (su == `DOM_SU_PANEL_NET);
    wire pe_ok = fn_pe[1] && ((mss == `DOM_MSS_ANY) || mss_sw || mss_ilock);

    // Mode requested by the inputs, by priority
    reg [3:0] req_mode;
    reg req_valid;
    always @* begin
        req_mode = mode_r;
        req_valid = 1'b0;
        if (en_ok) begin
            req_valid = 1'b1;
            if (fn_en[0]) begin
                req_mode = `DOM_MODE_NET;
            end else if (mss == `DOM_MSS_EXT) begin
                req_mode = `DOM_MODE_EXT;
            end else if (fn_pn[1]) begin
                req_mode = fn_pn[0] ? `DOM_MODE_PANEL : `DOM_MODE_EXT;
            end else if (fn_pe[1]) begin
                req_mode = fn_pe[0] ? `DOM_MODE_EXT : `DOM_MODE_PANEL;
            end else begin
                req_mode = `DOM_MODE_EXT;
            end
        end else if (pn_ok) begin
            req_valid = 1'b1;
            if (fn_en[1] && fn_en[0]) begin
                req_mode = `DOM_MODE_NET;
            end else if (fn_pn[0]) begin
                req_mode = `DOM_MODE_PANEL;
            end else if (mss_ilock) begin
                req_mode = (fn_pe[1] && fn_pe[0]) ? `DOM_MODE_EXT : `DOM_MODE_PANEL;
            end else begin
                req_mode = `DOM_MODE_NET;
            end
        end else if (pe_ok) begin
            req_valid = 1'b1;
            req_mode = fn_pe[0] ? `DOM_MODE_EXT : `DOM_MODE_PANEL;
        end else if (cmd_pend_r) begin
            req_valid = 1'b1;
            case (cmd_r)
                `DOM_CMD_PANEL: req_mode = `DOM_MODE_PANEL;
                `DOM_CMD_NET: req_mode = `DOM_MODE_NET;
                default: req_mode = `DOM_MODE_EXT;
            endcase
        end
    end

    // Gates a request against the settings and the run state
    // Ext-net input may step panel and network directly; commands only under the panel-net start-up setting
    wire pn_step = ((mode_r == `DOM_MODE_PANEL) && (req_mode == `DOM_MODE_NET)) ||
        ((mode_r == `DOM_MODE_NET) && (req_mode == `DOM_MODE_PANEL));
    wire blk_direct = pn_step && (su != `DOM_SU_PANEL_NET) && !en_ok;
    wire blk_start = mss_ilock && start_on && (req_mode == `DOM_MODE_PANEL);
    wire blk_panel = (mss == `DOM_MSS_EXT) && (req_mode == `DOM_MODE_PANEL);
    wire req_take = req_valid && run_ok && !blk_direct && !blk_start && !blk_panel;

    // Next mode: setting first, then interlock, then input requests
    always @* begin
        mode_nxt = mode_r;
        case (mss)
            `DOM_MSS_PANEL: mode_nxt = `DOM_MODE_PANEL;
            `DOM_MSS_COMB3: mode_nxt = `DOM_MODE_COMB;
            `DOM_MSS_COMB4: mode_nxt = `DOM_MODE_COMB;
            default: begin
                if (ilk_off) begin
                    mode_nxt = `DOM_MODE_EXT;
                end else if (mode_r == `DOM_MODE_COMB) begin
                    mode_nxt = `DOM_MODE_EXT;
                end else if ((mss == `DOM_MSS_EXT) && (mode_r == `DOM_MODE_PANEL)) begin
                    mode_nxt = `DOM_MODE_EXT;
                end else if (req_take) begin
                    mode_nxt = req_mode;
                end
            end
        endcase
    end

    // Mode register
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            mode_r <= `DOM_MODE_EXT;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Output stop: normal stop duty, or interlock stop in external mode
    wire stop_nxt = mss_ilock ? (ilk_on && (mode_r == `DOM_MODE_EXT)) :
        stop_level;
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            MODE <= `DOM_MODE_EXT;
            OUTPUT_STOP <= 1'b0;
        end else begin
            MODE <= mode_nxt;
            OUTPUT_STOP <= stop_nxt;
        end
    end

    // APB decode
    wire acc = PSEL && PENABLE && !PREADY;
    wire wr = acc && PWRITE;
    wire a_cfg = (PADDR == `DOM_CFG_ADDR);
    wire a_tfs = (PADDR >= `DOM_TFS0_ADDR) && (PADDR <= `DOM_TFS4_ADDR) &&
        (PADDR[1:0] == 2'b00);
    wire a_cmd = (PADDR == `DOM_CMD_ADDR);
    wire a_stat = (PADDR == `DOM_STAT_ADDR);
    wire mapped = a_cfg || a_tfs || a_cmd || a_stat;
    wire wr_lock = ilk_off && !a_cfg;
    wire wr_bad = !mapped || a_stat || wr_lock;
    wire [2:0] tfs_idx = PADDR[4:2] - 3'h1;

    // Setting registers; writes while locked change only the mode selection setting
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            mode_selection_setting_r <= `DOM_MSS_RST;
            startup_mode_setting_r <= `DOM_SU_RST;
            stop_input_logic_setting_r <= `DOM_SL_RST;
            tfs_r <= {5{`DOM_TFS_RST}};
        end else if (wr && !wr_bad) begin
            if (a_cfg) begin
                mode_selection_setting_r <= PWDATA[`DOM_CFG_MSS_LSB +: 3];
                if (!ilk_off) begin
                    startup_mode_setting_r <= PWDATA[`DOM_CFG_SU_LSB +: 4];
                    stop_input_logic_setting_r <= PWDATA[`DOM_CFG_SL_LSB +: 2];
                end
            end
            if (a_tfs) begin
                tfs_r[tfs_idx*7 +: 7] <= PWDATA[6:0];
            end
        end
    end

    // Software mode command: held until taken or dropped by a fixed setting or interlock off
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cmd_r <= `DOM_CMD_EXT;
            cmd_pend_r <= 1'b0;
        end else if (wr && !wr_bad && a_cmd && (PWDATA[1:0] != 2'b00)) begin
            cmd_r <= PWDATA[1:0];
            cmd_pend_r <= 1'b1;
        end else if (mss_fixed || ilk_off || (cmd_pend_r && (mode_nxt == req_mode))) begin
            cmd_pend_r <= 1'b0;
        end
    end

    // Read mux
    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h0000_0000;
        if (a_cfg) begin
            rd_val[`DOM_CFG_MSS_LSB +: 3] = mode_selection_setting_r;
            rd_val[`DOM_CFG_SU_LSB +: 4] = startup_mode_setting_r;
            rd_val[`DOM_CFG_SL_LSB +: 2] = stop_input_logic_setting_r;
        end else if (a_tfs) begin
            rd_val[6:0] = tfs_r[tfs_idx*7 +: 7];
        end else if (a_cmd) begin
            rd_val[2:0] = {cmd_pend_r, cmd_r};
        end else if (a_stat) begin
            rd_val[8:0] = {start_on, motor_run, ilk_off, OUTPUT_STOP, stopped, mode_r};
        end
    end

    // APB answer: one wait state, ready and data from flops
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= acc;
            PSLVERR <= acc && (PWRITE ? wr_bad : !mapped);
            if (acc && !PWRITE) begin
                PRDATA <= mapped ? rd_val : 32'h0000_0000;
            end
        end
    end

endmodule // dom_mode_sel

// File: dom_map.vh
/*
 * Register offsets, field positions, reset values and encodings of the
 * operation-mode selector. Included by the selector top only.
 */
`ifndef DOM_MAP_VH
`define DOM_MAP_VH

// APB byte addresses
`define DOM_CFG_ADDR 8'h00
`define DOM_TFS0_ADDR 8'h04
`define DOM_TFS4_ADDR 8'h14
`define DOM_CMD_ADDR 8'h18
`define DOM_STAT_ADDR 8'h1c

// Configuration register fields
`define DOM_CFG_MSS_LSB 0
`define DOM_CFG_SU_LSB 8
`define DOM_CFG_SL_LSB 16

// Reset values
`define DOM_MSS_RST 3'h0
`define DOM_SU_RST 4'h0
`define DOM_SL_RST 2'h0
`define DOM_TFS_RST 7'h00

// Terminal function codes
`define DOM_FN_INTERLOCK 7'h0c
`define DOM_FN_PANEL_EXT 7'h10
`define DOM_FN_PANEL_NET 7'h41
`define DOM_FN_EXT_NET 7'h42

// Mode selection, start-up and stop-logic setting values
`define DOM_MSS_ANY 3'h0
`define DOM_MSS_PANEL 3'h1
`define DOM_MSS_EXT 3'h2
`define DOM_MSS_COMB3 3'h3
`define DOM_MSS_COMB4 3'h4
`define DOM_MSS_SWOVER 3'h6
`define DOM_MSS_ILOCK 3'h7
`define DOM_SU_AS_MSS 4'h0
`define DOM_SU_NET 4'h1
`define DOM_SU_PANEL_NET 4'ha
`define DOM_SL_INVERT 2'h2

// Software mode command codes
`define DOM_CMD_EXT 2'h1
`define DOM_CMD_PANEL 2'h2
`define DOM_CMD_NET 2'h3

// One-hot operation modes
`define DOM_MODE_EXT 4'h1
`define DOM_MODE_PANEL 4'h2
`define DOM_MODE_NET 4'h4
`define DOM_MODE_COMB 4'h8

`endif

// File: dom_sync.v
/*
 * Two-flop synchroniser bank for asynchronous pin inputs.
 * Assumes one clock and an active-high asynchronous reset.
 */
module dom_sync #(
    parameter W = 9
) (
    input wire clk, // System clock
    input wire rst, // Async reset, high
    input wire [W-1:0] d, // Asynchronous inputs
    output wire [W-1:0] q // Synchronised inputs
);

    genvar i;
    // One two-stage chain per bit
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_r;
            reg s2_r;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                end else begin
                    s1_r <= d[i];
                    s2_r <= s1_r;
                end
            end
            assign q[i] = s2_r;
        end
    endgenerate

endmodule // dom_sync

// File: dom_mode_sel_checker.sv
/* Checker of mode and stop relations of the operation-mode selector.
   Assumes no terminal carries the interlock code, so the stop pin is the interlock. */
module dom_mode_sel_checker (
    input wire MCLK, // Clock
    input wire RST, // Async reset
    input wire PWRITE, // APB direction
    input wire [7:0] PADDR, // APB address
    input wire [31:0] PWDATA, // APB write data
    input wire PREADY, // APB ready
    input wire PSLVERR, // APB error
    input wire OUTPUT_STOP_IN, // Stop pin
    input wire FORWARD_START_IN, // Forward start
    input wire REVERSE_START_IN, // Reverse start
    input wire MOTOR_RUN_IN, // Motor running
    input wire [3:0] MODE, // Resolved mode
    input wire OUTPUT_STOP // Output held stopped
);
    reg [2:0] mss_r;
    reg [3:0] su_r;
    reg [1:0] sl_r;
    reg [4:0] en_r;
    wire ilk = OUTPUT_STOP_IN ^ (sl_r == 2'h2);
    wire go = FORWARD_START_IN | REVERSE_START_IN;
    // Shadow of accepted configuration writes
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            mss_r <= 3'h0;
            su_r <= 4'h0;
            sl_r <= 2'h0;
            en_r <= 5'h00;
        end else if (PREADY && !PSLVERR && PWRITE && PADDR == 8'h00) begin
            mss_r <= PWDATA[2:0];
            if (!(mss_r == 3'h7 && !ilk)) begin
                su_r <= PWDATA[11:8];
                sl_r <= PWDATA[17:16];
            end
        end else if (PREADY && !PSLVERR && PWRITE && PADDR >= 8'h04 && PADDR <= 8'h14) begin
            en_r[PADDR[4:2] - 3'h1] <= (PWDATA[6:0] == 7'h42);
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    property p_onehot; $onehot(MODE); endproperty
    property p_force; (mss_r == 3'h7 && !ilk) [*4] |-> MODE == 4'h1; endproperty
    property p_hold; (mss_r == 3'h7 && ilk && MODE == 4'h1) [*4] |-> OUTPUT_STOP; endproperty
    property p_stop; (mss_r != 3'h7 && $stable(ilk)) [*4] |-> OUTPUT_STOP == ilk; endproperty
    property p_run; (mss_r == 3'h0 && MOTOR_RUN_IN) [*4] |-> $stable(MODE); endproperty
    property p_nopanel; mss_r == 3'h2 [*2] |-> MODE != 4'h2; endproperty
    property p_nodirect; (MODE == 4'h2 && su_r != 4'ha && en_r == 5'h00) ##1
        (su_r != 4'ha && en_r == 5'h00) |-> MODE != 4'h4;
    endproperty
    property p_start; (mss_r == 3'h7 && ilk && go && MODE != 4'h2) [*4] |=> MODE != 4'h2;
    endproperty
    property p_lock;
        (mss_r == 3'h7 && !ilk) [*4] ##0 (PREADY && PWRITE && PADDR != 8'h00) |-> PSLVERR;
    endproperty
    a_onehot: assert property (p_onehot) else $error("mode not one-hot");
    a_force: assert property (p_force) else $error("external not forced");
    a_hold: assert property (p_hold) else $error("output not held stopped");
    a_stop: assert property (p_stop) else $error("stop output wrong level");
    a_run: assert property (p_run) else $error("mode changed while running");
    a_nopanel: assert property (p_nopanel) else $error("panel reached");
    a_nodirect: assert property (p_nodirect) else $error("panel to network step");
    a_start: assert property (p_start) else $error("panel taken with start on");
    a_lock: assert property (p_lock) else $error("locked write accepted");
    c_lock: cover property (mss_r == 3'h7 && !ilk && PREADY && PSLVERR);
    c_net: cover property (MODE == 4'h4);
    c_hold: cover property (mss_r == 3'h7 && OUTPUT_STOP && MODE == 4'h1);
endmodule // dom_mode_sel_checker

bind dom_mode_sel dom_mode_sel_checker u_chk (.MCLK, .RST, .PWRITE, .PADDR, .PWDATA,
    .PREADY, .PSLVERR, .OUTPUT_STOP_IN, .FORWARD_START_IN, .REVERSE_START_IN,
    .MOTOR_RUN_IN, .MODE, .OUTPUT_STOP);

// File: dom_motor_model.sv
/* Motor at the drive's far side: spins up under a start command.
   Assumes the selector's output-stop level and the start pins. */
module dom_motor_model #(
    parameter DELAY = 4
) (
    input wire clk, // Clock
    input wire rst, // Async reset
    input wire fwd, // Forward start
    input wire rev, // Reverse start
    input wire stop, // Output held stopped
    output reg run // Motor turning
);
    reg [3:0] cnt_r;
    // Spin up while driven, coast down otherwise
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h0;
            run <= 1'b0;
        end else begin
            if ((fwd || rev) && !stop) begin
                cnt_r <= (cnt_r == DELAY) ? cnt_r : cnt_r + 4'h1;
            end else begin
                cnt_r <= (cnt_r == 4'h0) ? cnt_r : cnt_r - 4'h1;
            end
            run <= (cnt_r == DELAY) ? 1'b1 : (cnt_r == 4'h0) ? 1'b0 : run;
        end
    end
endmodule // dom_motor_model

// File: dom_mode_sel_tb.sv
/* Testbench of the operation-mode selector: APB setup, pin scenarios.
   Assumes the motor model on the far side and no interlock terminal code. */
module dom_mode_sel_tb;
    timeunit 1ns;
    timeprecision 100ps;
    reg MCLK, RST, PSEL, PENABLE, PWRITE, OUTPUT_STOP_IN, FORWARD_START_IN, REVERSE_START_IN;
    reg [7:0] PADDR;
    reg [31:0] PWDATA;
    reg [4:0] TERM_IN;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, MOTOR_RUN_IN, OUTPUT_STOP;
    wire [3:0] MODE;
    int num_errors = 0;
    int checks = 0;
    dom_mode_sel dut (.MCLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .TERM_IN, .OUTPUT_STOP_IN, .FORWARD_START_IN,
        .REVERSE_START_IN, .MOTOR_RUN_IN, .MODE, .OUTPUT_STOP);
    dom_motor_model #(.DELAY(4)) u_motor (.clk(MCLK), .rst(RST), .fwd(FORWARD_START_IN),
        .rev(REVERSE_START_IN), .stop(OUTPUT_STOP), .run(MOTOR_RUN_IN));
    // Free-running clock
    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end
    // Verdict and end of run
    task conclude;
        $display("Errors %0d, checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task ck(input [31:0] g, input [31:0] x);
        checks++;
        if (g !== x) begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, g, x);
        end
    endtask
    // One APB transfer, answer taken at the ready edge
    task acc(input w, input [7:0] a, input [31:0] d, input [31:0] xd, input xe);
        int n;
        n = 0;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (PREADY !== 1'b1) begin
            num_errors++;
            conclude;
        end
        if (!w) ck(PRDATA, xd);
        ck({31'h0, PSLVERR}, {31'h0, xe});
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // Pin levels, then time to cross synchronisers and motor
    task pins(input [4:0] t, input s, input f, input r);
        @(posedge MCLK);
        TERM_IN <= t;
        OUTPUT_STOP_IN <= s;
        FORWARD_START_IN <= f;
        REVERSE_START_IN <= r;
        repeat (10) @(posedge MCLK);
        #1;
    endtask
    task md(input [3:0] x, input st);
        ck({28'h0, MODE}, {28'h0, x});
        ck({31'h0, OUTPUT_STOP}, {31'h0, st});
    endtask
    // Main sequence
    initial begin
        int k;
        RST = 1'b1;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {TERM_IN, OUTPUT_STOP_IN, FORWARD_START_IN, REVERSE_START_IN} = '0;
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        pins(5'h00, 1'b0, 1'b0, 1'b0);
        md(4'h1, 1'b0);
        acc(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
        acc(1'b0, 8'h04, 32'h0, 32'h0, 1'b0);
        acc(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
        acc(1'b1, 8'h04, 32'h10, 32'h0, 1'b0);
        pins(5'h01, 1'b0, 1'b0, 1'b0);
        md(4'h1, 1'b0);
        pins(5'h00, 1'b0, 1'b0, 1'b0);
        md(4'h2, 1'b0);
        pins(5'h00, 1'b0, 1'b1, 1'b0);
        pins(5'h01, 1'b0, 1'b1, 1'b0);
        md(4'h2, 1'b0);
        acc(1'b1, 8'h00, 32'h6, 32'h0, 1'b0);
        pins(5'h01, 1'b0, 1'b1, 1'b0);
        md(4'h1, 1'b0);
        pins(5'h01, 1'b0, 1'b0, 1'b0);
        for (k = 1; k < 5; k++) begin
            acc(1'b1, 8'h00, k[31:0], 32'h0, 1'b0);
            pins(5'h00, 1'b0, 1'b0, 1'b0);
            md((k == 1) ? 4'h2 : (k == 2) ? 4'h1 : 4'h8, 1'b0);
        end
        acc(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
        acc(1'b1, 8'h08, 32'h42, 32'h0, 1'b0);
        pins(5'h03, 1'b0, 1'b0, 1'b0);
        md(4'h4, 1'b0);
        pins(5'h01, 1'b0, 1'b0, 1'b0);
        md(4'h1, 1'b0);
        pins(5'h00, 1'b0, 1'b0, 1'b0);
        md(4'h2, 1'b0);
        pins(5'h02, 1'b0, 1'b0, 1'b0);
        md(4'h4, 1'b0);
        acc(1'b1, 8'h00, 32'ha00, 32'h0, 1'b0);
        acc(1'b1, 8'h0c, 32'h41, 32'h0, 1'b0);
        pins(5'h04, 1'b0, 1'b0, 1'b0);
        md(4'h2, 1'b0);
        pins(5'h00, 1'b0, 1'b0, 1'b0);
        md(4'h4, 1'b0);
        pins(5'h06, 1'b0, 1'b0, 1'b0);
        md(4'h4, 1'b0);
        acc(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
        pins(5'h00, 1'b0, 1'b0, 1'b0);
        md(4'h1, 1'b0);
        acc(1'b1, 8'h08, 32'h0, 32'h0, 1'b0);
        acc(1'b1, 8'h0c, 32'h0, 32'h0, 1'b0);
        acc(1'b1, 8'h00, 32'h7, 32'h0, 1'b0);
        pins(5'h00, 1'b0, 1'b0, 1'b0);
        md(4'h1, 1'b0);
        acc(1'b1, 8'h10, 32'h10, 32'h0, 1'b1);
        pins(5'h00, 1'b1, 1'b0, 1'b0);
        md(4'h2, 1'b0);
        pins(5'h01, 1'b1, 1'b0, 1'b0);
        md(4'h1, 1'b1);
        pins(5'h00, 1'b1, 1'b0, 1'b1);
        md(4'h1, 1'b1);
        pins(5'h01, 1'b1, 1'b0, 1'b0);
        acc(1'b1, 8'h00, 32'h20007, 32'h0, 1'b0);
        pins(5'h01, 1'b0, 1'b0, 1'b0);
        md(4'h1, 1'b1);
        pins(5'h00, 1'b0, 1'b0, 1'b0);
        md(4'h2, 1'b0);
        acc(1'b1, 8'h00, 32'h20000, 32'h0, 1'b0);
        pins(5'h00, 1'b0, 1'b0, 1'b0);
        md(4'h2, 1'b1);
        pins(5'h00, 1'b1, 1'b0, 1'b0);
        md(4'h2, 1'b0);
        acc(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
        pins(5'h00, 1'b1, 1'b0, 1'b0);
        md(4'h2, 1'b1);
        acc(1'b1, 8'h04, 32'h0, 32'h0, 1'b0);
        acc(1'b1, 8'h18, 32'h3, 32'h0, 1'b0);
        pins(5'h00, 1'b1, 1'b0, 1'b0);
        md(4'h2, 1'b1);
        acc(1'b0, 8'h18, 32'h0, 32'h7, 1'b0);
        acc(1'b1, 8'h18, 32'h1, 32'h0, 1'b0);
        pins(5'h00, 1'b1, 1'b0, 1'b0);
        md(4'h1, 1'b1);
        acc(1'b0, 8'h1c, 32'h0, 32'h31, 1'b0);
        conclude;
    end
endmodule // dom_mode_sel_tb
